// >>> src/pwg_pkg.sv
// Constants of the programmable word generator.
// Assumes one 20 MHz system clock; the bit clock is a sampled input.
// Function
// - Word length 2 to 16 bits, fixed by a static internal setting.
// - Word loads into shift register in parallel between words.
// - Data store follows parallel inputs while end-of-word is active.
// - Emitted word equals input held stable before and through END.
// - Only start leading edge acts; any width accepted.
// - Format NRZ or RZ, from panel or programming input.
// - RZ one bits give one clk pulses, shorter than half the bit period when it exceeds 2 clk.
// - Word sent true or complemented by selection.
// - Words started by auto recycle, external start or manual push.
// - Auto mode repeats word with one clock period between words.
// - Manual word starts on start or push, lasts word length clocks.
// - Set shifts ones in serially; all ones after 16 clocks.
// - Clear zeroes all stages at once without bit clocking.
// - Pseudo-random mode gives 32767-bit sequence seeded from register.
// - Programming drives data bits, format, random and auto choices.
// - End output is complement of word-active; counter preset while false.
// - Length counter preset from 17's complement code of length.
// - Enabled panel settings override programming inputs.
package pwg_pkg;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          RZ_WIDTH_NS   = 50;
  localparam int          RZ_CYCLES     =
    (RZ_WIDTH_NS / CLK_PERIOD_NS < 1) ? 1 : RZ_WIDTH_NS / CLK_PERIOD_NS;
  localparam int          WORD_W        = 16;
  localparam logic [3:0]  LEN_CODE_RST  = 4'h1;
  localparam logic [4:0]  CNT_END       = 5'h10;
  localparam int          TAP_A         = 13;
  localparam int          TAP_B         = 14;
  // Register map
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_PANEL    = 4'h4;
  localparam logic [3:0]  ADDR_STATUS   = 4'h8;
  localparam logic [3:0]  ADDR_SHIFT    = 4'hc;
  localparam logic [5:0]  CTRL_RST      = 6'h00;
  localparam int          CTRL_PANEL_EN = 0;
  localparam int          CTRL_RZ       = 1;
  localparam int          CTRL_AUTO     = 2;
  localparam int          CTRL_COMPL    = 3;
  localparam int          CTRL_RANDOM   = 4;
  localparam int          CTRL_SET      = 5;
  localparam int          CTRL_PUSH     = 8;
  localparam int          CTRL_CLEAR    = 9;
endpackage

// >>> src/pwg_word_gen.sv
// Word generator core with plain register port.
// Bit clock, start and programming pins are synchronous to clk.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module pwg_word_gen #(
  parameter logic [3:0] LEN_CODE = pwg_pkg::LEN_CODE_RST
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        bit_clk,
  input  wire logic        start_in,
  input  wire logic [15:0] prog_word,
  input  wire logic        prog_rz,
  input  wire logic        prog_auto,
  input  wire logic        pseudo_random_mode,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rd_data,
  output logic             word_out,
  output logic             end_out
);
  // ****************************************
  // Register port
  // ****************************************
  logic [5:0]  ctrl_q;
  logic [15:0] panel_q;
  logic        push_p;
  logic        clear_p;
  logic [31:0] rd_d;

  assign push_p  = wr_en && addr == pwg_pkg::ADDR_CTRL
                   && wr_data[pwg_pkg::CTRL_PUSH];
  assign clear_p = wr_en && addr == pwg_pkg::ADDR_CTRL
                   && wr_data[pwg_pkg::CTRL_CLEAR];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= pwg_pkg::CTRL_RST;
    end else if (wr_en && addr == pwg_pkg::ADDR_CTRL) begin
      ctrl_q <= wr_data[5:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      panel_q <= 16'h0000;
    end else if (wr_en && addr == pwg_pkg::ADDR_PANEL) begin
      panel_q <= wr_data[15:0];
    end
  end

  // ****************************************
  // Mode selection
  // ****************************************
  logic        panel_en;
  logic        rz_eff;
  logic        auto_eff;
  logic        random_eff;
  logic        compl_eff;
  logic        set_hold;
  logic [15:0] data_eff;

  assign panel_en  = ctrl_q[pwg_pkg::CTRL_PANEL_EN];
  assign rz_eff    = panel_en ? ctrl_q[pwg_pkg::CTRL_RZ]   : prog_rz;
  assign auto_eff  = panel_en ? ctrl_q[pwg_pkg::CTRL_AUTO] : prog_auto;
  assign random_eff = panel_en ? ctrl_q[pwg_pkg::CTRL_RANDOM]
                               : pseudo_random_mode;
  assign data_eff  = panel_en ? panel_q : prog_word;
  assign compl_eff = ctrl_q[pwg_pkg::CTRL_COMPL];
  assign set_hold  = ctrl_q[pwg_pkg::CTRL_SET];

  // ****************************************
  // Edge detection
  // ****************************************
  logic bit_clk_q;
  logic start_q;
  logic tick;
  logic start_edge;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_clk_q <= 1'b0;
      start_q   <= 1'b0;
    end else begin
      bit_clk_q <= bit_clk;
      start_q   <= start_in;
    end
  end

  assign tick       = bit_clk && !bit_clk_q;
  assign start_edge = start_in && !start_q;

  // ****************************************
  // Word state and length counter
  // ****************************************
  logic        active_q;
  logic        pend_q;
  logic [4:0]  cnt_q;
  logic        consume;

  assign consume = tick && !active_q && !random_eff;

  // start sources; set wins over consume
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (start_edge || push_p) begin
      pend_q <= 1'b1;
    end else if (consume) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
    end else if (random_eff) begin
      active_q <= 1'b1;
    end else if (tick) begin
      if (!active_q) begin
        active_q <= auto_eff || pend_q;
      end else if (cnt_q == pwg_pkg::CNT_END) begin
        active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {1'b0, LEN_CODE};
    end else if (tick && !random_eff) begin
      if (!active_q) begin
        cnt_q <= {1'b0, LEN_CODE};
      end else if (cnt_q != pwg_pkg::CNT_END) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // ****************************************
  // Data store and shift register
  // ****************************************
  logic [15:0] store_q;
  logic [15:0] shreg_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      store_q <= 16'h0000;
    end else if (!active_q) begin
      store_q <= data_eff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shreg_q <= 16'h0000;
    end else if (clear_p) begin
      shreg_q <= 16'h0000;
    end else if (tick) begin
      if (set_hold) begin
        shreg_q <= {shreg_q[14:0], 1'b1};
      end else if (random_eff) begin
        shreg_q <= {shreg_q[14:0],
                    shreg_q[pwg_pkg::TAP_A] ^ shreg_q[pwg_pkg::TAP_B]};
      end else if (!active_q) begin
        shreg_q <= store_q;
      end else begin
        shreg_q <= {shreg_q[14:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Output format
  // ****************************************
  // RZ pulse is one clk wide; only under half a bit period
  // when the bit period is longer than two clk periods.
  logic rz_pulse_q;
  logic bit_val;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rz_pulse_q <= 1'b0;
    end else begin
      rz_pulse_q <= tick;
    end
  end

  assign bit_val = shreg_q[pwg_pkg::WORD_W-1] ^ compl_eff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_out <= 1'b0;
    end else if (!active_q) begin
      word_out <= 1'b0;
    end else if (rz_eff) begin
      word_out <= bit_val && rz_pulse_q;
    end else begin
      word_out <= bit_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      end_out <= 1'b1;
    end else begin
      end_out <= !active_q;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_comb begin
    rd_d = 32'h0000_0000;
    case (addr)
      pwg_pkg::ADDR_CTRL:   rd_d[5:0]  = ctrl_q;
      pwg_pkg::ADDR_PANEL:  rd_d[15:0] = panel_q;
      pwg_pkg::ADDR_STATUS: rd_d[8:0]  =
        {cnt_q, random_eff, rz_eff, pend_q, active_q};
      pwg_pkg::ADDR_SHIFT:  rd_d[15:0] = shreg_q;
      default:              rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en) begin
      rd_data <= rd_d;
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_load;
    tick && !active_q && !random_eff && !set_hold && !clear_p
      |=> shreg_q == $past(store_q);
  endproperty
  a_load: assert property (p_load)
    else $error("shift register not loaded");
  // Release edge skipped: state is still held in reset there
  property p_store;
    !rst && !active_q |=> store_q == $past(data_eff);
  endproperty
  a_store: assert property (p_store)
    else $error("store missed input data");
  property p_start;
    !rst && start_edge && !random_eff |=> pend_q;
  endproperty
  a_start: assert property (p_start)
    else $error("start edge lost");
  property p_auto;
    tick && !active_q && auto_eff && !random_eff |=> active_q;
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto recycle missed");
  property p_manual;
    tick && !active_q && !auto_eff && !pend_q && !random_eff
      && !start_edge && !push_p |=> !active_q ##1 end_out;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual word without start");
  property p_set;
    tick && set_hold && !clear_p |=> shreg_q[0];
  endproperty
  a_set: assert property (p_set)
    else $error("set did not shift a one");
  property p_clear;
    clear_p |=> shreg_q == 16'h0000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear failed");
  property p_random;
    tick && random_eff && !set_hold && !clear_p
      |=> shreg_q[0] == $past(shreg_q[13] ^ shreg_q[14]);
  endproperty
  a_random: assert property (p_random)
    else $error("random feedback wrong");
  property p_random_active;
    !rst && random_eff |=> active_q ##1 !end_out;
  endproperty
  a_random_active: assert property (p_random_active)
    else $error("end seen in random mode");
  property p_end;
    tick && active_q && !random_eff && cnt_q == pwg_pkg::CNT_END
      |=> !active_q ##1 end_out;
  endproperty
  a_end: assert property (p_end)
    else $error("word did not end");
  property p_shift;
    tick && active_q && !random_eff && !set_hold && !clear_p
      |=> shreg_q == {$past(shreg_q[14:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift)
    else $error("shift step wrong");
  property p_rz;
    active_q && rz_eff && !rz_pulse_q |=> !word_out;
  endproperty
  a_rz: assert property (p_rz)
    else $error("rz pulse too wide");
  property p_nrz;
    active_q && !rz_eff |=> word_out == $past(bit_val);
  endproperty
  a_nrz: assert property (p_nrz)
    else $error("nrz bit wrong");

  c_auto_word: cover property (tick && active_q && auto_eff
                               && cnt_q == pwg_pkg::CNT_END);
  c_manual: cover property (consume && pend_q && !auto_eff);
  c_random: cover property (tick && random_eff);
  c_clear: cover property (clear_p && active_q);
endmodule

// >>> verification/pwg_rate_src.sv
// Bit clock source standing in for the external rate generator.
// Assumes clk from the bench; the bit clock stays low while disabled.
`timescale 1ns/1ps
module pwg_rate_src #(
  parameter int HALF = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  output logic      bit_clk
);
  logic [7:0] cnt_q;

  // bit period of 8 clk keeps END well above 0.2 us
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= 8'h00;
      bit_clk <= 1'b0;
    end else if (!en) begin
      cnt_q   <= 8'h00;
      bit_clk <= 1'b0;
    end else if (cnt_q == 8'(HALF - 1)) begin
      cnt_q   <= 8'h00;
      bit_clk <= ~bit_clk;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the word generator core, 4-bit words.
// Assumes the rate source model; the bench drives all other inputs.
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [3:0] LEN = 4'hd;
  localparam int         WL  = 4;
  typedef struct {
    logic [7:0]  ctrl;
    logic [15:0] pw;
    logic [15:0] pan;
    logic        prz;
    logic [3:0]  ex;
    logic        rz;
  } pwg_row_s;
  logic        clk, rst, bit_clk, clk_en, start_in, prog_rz, prog_auto;
  logic        random_sel, wr_en, rd_en, word_out, end_out, wv, ev;
  logic [15:0] prog_word, s;
  logic [3:0]  addr;
  logic [31:0] wr_data, rd_data, rv;
  int          mismatches, compares, hi;
  pwg_row_s    rows [6] = '{
    '{8'h04, 16'ha000, 16'h5000, 1'b0, 4'ha, 1'b0},
    '{8'h04, 16'h3000, 16'h0000, 1'b1, 4'h3, 1'b1},
    '{8'h05, 16'h9000, 16'h6000, 1'b1, 4'h6, 1'b0},
    '{8'h0d, 16'h9000, 16'h5000, 1'b0, 4'ha, 1'b0},
    '{8'h07, 16'h0000, 16'hc000, 1'b0, 4'hc, 1'b1},
    '{8'h04, 16'h0fff, 16'h0000, 1'b0, 4'h0, 1'b0}
  };

  pwg_word_gen #(
    .LEN_CODE (LEN)
  ) u_dut (
    .clk                (clk),
    .rst                (rst),
    .bit_clk            (bit_clk),
    .start_in           (start_in),
    .prog_word          (prog_word),
    .prog_rz            (prog_rz),
    .prog_auto          (prog_auto),
    .pseudo_random_mode (random_sel),
    .addr               (addr),
    .wr_data            (wr_data),
    .wr_en              (wr_en),
    .rd_en              (rd_en),
    .rd_data            (rd_data),
    .word_out           (word_out),
    .end_out            (end_out)
  );

  pwg_rate_src u_src (
    .clk     (clk),
    .rst     (rst),
    .en      (clk_en),
    .bit_clk (bit_clk)
  );

  always #25 clk = ~clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask

  // One bit period; RZ pulses counted, levels taken mid-bit
  task automatic win();
    @(posedge bit_clk);
    hi = 0;
    for (int k = 1; k < 8; k++) begin
      @(posedge clk);
      #1;
      hi += int'(word_out === 1'b1);
      if (k == 4) begin
        wv = word_out;
        ev = end_out;
      end
    end
  endtask

  task automatic wait_end();
    ev = 1'b0;
    for (int n = 0; n < 12 && ev !== 1'b1; n++) begin
      win();
    end
  endtask

  task automatic bits(input logic [3:0] ex, input logic rz);
    for (int i = WL - 1; i >= 0; i--) begin
      win();
      chk({31'h0, ev}, 32'h0);
      if (rz) begin
        chk(32'(hi), {31'h0, ex[i]});
      end else begin
        chk({31'h0, wv}, {31'h0, ex[i]});
      end
    end
    win();
    chk({31'h0, ev}, 32'h1);
  endtask

  task automatic wrap_up();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end

  initial begin
    clk        = 1'b0;
    rst        = 1'b1;
    clk_en     = 1'b0;
    start_in   = 1'b0;
    prog_word  = 16'h0;
    prog_rz    = 1'b0;
    prog_auto  = 1'b1;
    random_sel = 1'b0;
    addr       = 4'h0;
    wr_data    = 32'h0;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({30'h0, end_out, word_out}, 32'h2);
    rd(pwg_pkg::ADDR_CTRL);
    chk(rv, 32'h0);
    rd(pwg_pkg::ADDR_STATUS);
    chk(rv, {23'h0, 1'b0, LEN, 4'h0});
    rd(4'h2);
    chk(rv, 32'h0);
    clk_en <= 1'b1;
    foreach (rows[i]) begin
      wr(pwg_pkg::ADDR_CTRL, {24'h0, rows[i].ctrl});
      wr(pwg_pkg::ADDR_PANEL, {16'h0, rows[i].pan});
      prog_word <= rows[i].pw;
      prog_rz   <= rows[i].prz;
      wait_end();
      chk({31'h0, ev}, 32'h1);
      bits(rows[i].ex, rows[i].rz);
      win();
      chk({31'h0, ev}, 32'h0);
    end
    // Manual: one word per start edge or push, none otherwise
    wr(pwg_pkg::ADDR_CTRL, 32'h0);
    prog_auto <= 1'b0;
    prog_word <= 16'h5000;
    wait_end();
    win();
    chk({31'h0, ev}, 32'h1);
    repeat (3) @(posedge clk);
    start_in <= 1'b1;
    @(posedge clk);
    start_in <= 1'b0;
    bits(4'h5, 1'b0);
    repeat (2) @(posedge clk);
    prog_word <= 16'h6000;
    wr(pwg_pkg::ADDR_CTRL, 32'h100);
    bits(4'h6, 1'b0);
    wr(pwg_pkg::ADDR_CTRL, 32'h21);
    repeat (16) win();
    @(posedge clk);
    clk_en <= 1'b0;
    rd(pwg_pkg::ADDR_SHIFT);
    chk(rv, 32'hffff);
    wr(pwg_pkg::ADDR_CTRL, 32'h0);
    random_sel <= 1'b1;
    clk_en     <= 1'b1;
    s = 16'hffff;
    for (int j = 0; j < 24; j++) begin
      s = {s[14:0], s[13] ^ s[14]};
      win();
      chk({30'h0, ev, wv}, {31'h0, s[15]});
    end
    @(posedge clk);
    clk_en <= 1'b0;
    wr(pwg_pkg::ADDR_CTRL, 32'h201);
    rd(pwg_pkg::ADDR_SHIFT);
    chk(rv, 32'h0);
    // Second reset mid-run, random mode still selected
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({30'h0, end_out, word_out}, 32'h2);
    rd(pwg_pkg::ADDR_STATUS);
    chk(rv, {23'h0, 1'b0, LEN, 4'h9});
    wrap_up();
  end
endmodule
